// ===== wcrc_defines.svh
`ifndef WCRC_DEFINES_SVH
`define WCRC_DEFINES_SVH
// Frame shape in unit intervals
`define WCRC_FRAME_UI   10
`define WCRC_LAST_UI    4'd9
`define WCRC_CRC_UI     4'd8
`define WCRC_DATA_UI    4'd4
`define WCRC_FIRST_UI   4'd0
// Tree layout
`define WCRC_TREE_BITS  72
`define WCRC_LANE_BITS  8
`define WCRC_A2_OFS     4
`define WCRC_MASK_POS   64
// Checksum generator
`define WCRC_POLY       8'h07
`define WCRC_INIT       8'h00
// Reset values
`define WCRC_CNT_RST    4'h0
`define WCRC_DQ_IDLE    16'hFFFF
`define WCRC_DMI_IDLE   2'h3
`endif

// ===== wcrc_pkg.sv
package wcrc_pkg;
  `include "wcrc_defines.svh"

  typedef logic [`WCRC_TREE_BITS-1:0] wcrc_tree_t;
  typedef logic [7:0]                 wcrc_crc_t;
  typedef enum logic [0:0] {
    WCRC_IDLE = 1'b0,
    WCRC_SEND = 1'b1
  } wcrc_state_t;

  // Builds one 72-input tree; dq4[4k+b] is lane k, beat b; unused positions are ones
  function automatic wcrc_tree_t wcrc_tree(input logic [31:0] dq4, input logic [3:0] dmi4,
                                           input logic a2, input logic dm_or_dbi);
    wcrc_tree_t t;
    int         ofs;
    t   = '1;
    ofs = a2 ? `WCRC_A2_OFS : 0;
    for (int k = 0; k < 8; k++) begin
      for (int b = 0; b < 4; b++) begin
        t[k*`WCRC_LANE_BITS + ofs + b] = dq4[4*k + b];
      end
    end
    if (dm_or_dbi) begin
      for (int b = 0; b < 4; b++) begin
        t[`WCRC_MASK_POS + ofs + b] = dmi4[b];
      end
    end
    return t;
  endfunction

  // Eight checksum bits over the tree, highest input first
  function automatic wcrc_crc_t wcrc_calc(input wcrc_tree_t d);
    wcrc_crc_t c;
    logic      fb;
    c = `WCRC_INIT;
    for (int i = `WCRC_TREE_BITS-1; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? `WCRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// ===== wcrc_link_if.sv
`timescale 1ns/1ps
interface wcrc_link_if;
  logic        link_clk;
  logic        frame;
  logic        a2;
  logic [15:0] dq;
  logic [1:0]  dmi;

  modport host (output link_clk, output frame, output a2, output dq, output dmi);
  modport device (input link_clk, input frame, input a2, input dq, input dmi);
endinterface

// ===== wcrc_device.sv
`timescale 1ns/1ps
`include "wcrc_defines.svh"
// Behaviour
// [R1] Lower lane k: data, ones, CRCk, one
// [R2] Upper lane 8+k: data then CRC 8+k
// [R3] Upper mask lane: data beats, then ones
// [R4] A2 high shifts data into upper nibbles
// [R5] Lower mask inputs used only if DM/DBI
// [R6] Upper mask inputs used only if DM/DBI
// [R7] A2 low tree: XOR subset, ones elsewhere
// [R8] A2 high tree: upper-half positions only
// [R9] Check CRC before committing any data
// [R10] Mismatch blocks write, discards burst; here wr_valid still pulses and only the failing tree's byte enables clear
// [R11] Per-byte blocking follows failing tree
// [R12] Controller issues no MPR writes
// [R13] Controller uses no per-device addressing
// [R14] Every write frame is ten UI
// [R15] Two identical trees, 72 inputs each
module wcrc_device #(
  parameter logic PER_BYTE_MASK = 1'b1
) (
  // System side
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Configuration
  input  wire logic        dm_en,
  input  wire logic        dbi_en,
  // Link
  wcrc_link_if.device      lnk,
  // Committed write
  output logic             wr_valid,
  output logic [63:0]      wr_data,
  output logic [7:0]       wr_be,
  output logic [1:0]       crc_err
);
  import wcrc_pkg::*;

  // Link domain state
  logic [3:0]  cnt_reg,      cnt_next;
  logic        a2_reg,       a2_next;
  logic [31:0] lo_reg,       lo_next;
  logic [31:0] hi_reg,       hi_next;
  logic [7:0]  dmi_reg,      dmi_next;
  logic [15:0] crc_rx_reg,   crc_rx_next;
  logic [63:0] res_data_reg, res_data_next;
  logic [7:0]  res_be_reg,   res_be_next;
  logic [1:0]  res_err_reg,  res_err_next;
  logic        res_tgl_reg,  res_tgl_next;
  logic        dm_s1_reg,    dm_s2_reg;
  logic        dbi_s1_reg,   dbi_s2_reg;
  // System domain state
  logic        tgl_s1_reg,   tgl_s2_reg,   tgl_s3_reg;
  logic        wr_valid_reg, wr_valid_next;
  logic [63:0] wr_data_reg,  wr_data_next;
  logic [7:0]  wr_be_reg,    wr_be_next;
  logic [1:0]  crc_err_reg,  crc_err_next;

  // Config levels into the link domain
  always_ff @(posedge lnk.link_clk or negedge rst_b) begin
    if (!rst_b) begin
      dm_s1_reg  <= 1'b0;
      dm_s2_reg  <= 1'b0;
      dbi_s1_reg <= 1'b0;
      dbi_s2_reg <= 1'b0;
    end else begin
      dm_s1_reg  <= dm_en;
      dm_s2_reg  <= dm_s1_reg;
      dbi_s1_reg <= dbi_en;
      dbi_s2_reg <= dbi_s1_reg;
    end
  end

  // Beat capture, check and result on the link clock
  always_comb begin
    wcrc_crc_t   crc_lo;
    wcrc_crc_t   crc_hi;
    logic [1:0]  err;
    logic [1:0]  blk;
    logic [63:0] data;
    logic [7:0]  be;
    logic        mask_used;
    crc_lo        = 8'h00;
    crc_hi        = 8'h00;
    err           = 2'b00;
    blk           = 2'b00;
    data          = '0;
    be            = '0;
    mask_used     = dm_s2_reg | dbi_s2_reg;
    cnt_next      = cnt_reg;
    a2_next       = a2_reg;
    lo_next       = lo_reg;
    hi_next       = hi_reg;
    dmi_next      = dmi_reg;
    crc_rx_next   = crc_rx_reg;
    res_data_next = res_data_reg;
    res_be_next   = res_be_reg;
    res_err_next  = res_err_reg;
    res_tgl_next  = res_tgl_reg;
    if (!lnk.frame) begin
      // Broken frame is abandoned
      cnt_next = `WCRC_CNT_RST;
    end else begin
      if (cnt_reg == `WCRC_FIRST_UI) begin
        a2_next = lnk.a2;
      end
      // Beats 0 to 3 carry data; 4 to 7 are ones and ignored
      if (cnt_reg < `WCRC_DATA_UI) begin // R1
        for (int k = 0; k < 8; k++) begin
          lo_next[4*k + cnt_reg[1:0]] = lnk.dq[k];
          hi_next[4*k + cnt_reg[1:0]] = lnk.dq[8+k]; // R2
        end
        dmi_next[cnt_reg[1:0]]     = lnk.dmi[0];
        dmi_next[4 + cnt_reg[1:0]] = lnk.dmi[1]; // R3
      end
      if (cnt_reg == `WCRC_CRC_UI) begin
        crc_rx_next = lnk.dq; // R1 R2
      end
      // Last UI: check both trees, then publish
      if (cnt_reg == `WCRC_LAST_UI) begin // R14
        crc_lo = wcrc_calc(wcrc_tree(lo_reg, dmi_reg[3:0], a2_reg, mask_used)); // R4 R5 R7 R8 R15
        crc_hi = wcrc_calc(wcrc_tree(hi_reg, dmi_reg[7:4], a2_reg, mask_used)); // R4 R6 R15
        err[0] = crc_lo != crc_rx_reg[7:0];
        err[1] = crc_hi != crc_rx_reg[15:8];
        blk    = PER_BYTE_MASK ? err : {2{|err}}; // R10 R11
        for (int b = 0; b < 4; b++) begin
          for (int k = 0; k < 8; k++) begin
            data[b*16 + k]     = lo_reg[4*k + b];
            data[b*16 + 8 + k] = hi_reg[4*k + b];
          end
          for (int j = 0; j < 2; j++) begin
            // Inversion lane low flips the byte
            if (dbi_s2_reg && !dmi_reg[j*4 + b]) begin
              data[b*16 + 8*j +: 8] = ~data[b*16 + 8*j +: 8];
            end
            be[b*2 + j] = !(dm_s2_reg && !dmi_reg[j*4 + b]) && !blk[j]; // R10
          end
        end
        res_data_next = data;
        res_be_next   = be;
        res_err_next  = err;
        res_tgl_next  = !res_tgl_reg; // R9
      end
      cnt_next = (cnt_reg == `WCRC_LAST_UI) ? `WCRC_CNT_RST : cnt_reg + 4'd1;
    end
  end

  // Link domain registers
  always_ff @(posedge lnk.link_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg      <= `WCRC_CNT_RST;
      a2_reg       <= 1'b0;
      lo_reg       <= '1;
      hi_reg       <= '1;
      dmi_reg      <= '1;
      crc_rx_reg   <= 16'h0000;
      res_data_reg <= '0;
      res_be_reg   <= 8'h00;
      res_err_reg  <= 2'b00;
      res_tgl_reg  <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      a2_reg       <= a2_next;
      lo_reg       <= lo_next;
      hi_reg       <= hi_next;
      dmi_reg      <= dmi_next;
      crc_rx_reg   <= crc_rx_next;
      res_data_reg <= res_data_next;
      res_be_reg   <= res_be_next;
      res_err_reg  <= res_err_next;
      res_tgl_reg  <= res_tgl_next;
    end
  end

  // Result toggle into the system domain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= res_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // Commit only after the check; result words stand stable meanwhile
  always_comb begin
    wr_valid_next = 1'b0;
    wr_data_next  = wr_data_reg;
    wr_be_next    = wr_be_reg;
    crc_err_next  = 2'b00;
    if (tgl_s2_reg ^ tgl_s3_reg) begin // R9
      wr_valid_next = 1'b1;
      wr_data_next  = res_data_reg;
      wr_be_next    = res_be_reg; // R10 R11
      crc_err_next  = res_err_reg;
    end
  end

  // System domain registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_valid_reg <= 1'b0;
      wr_data_reg  <= '0;
      wr_be_reg    <= 8'h00;
      crc_err_reg  <= 2'b00;
    end else begin
      wr_valid_reg <= wr_valid_next;
      wr_data_reg  <= wr_data_next;
      wr_be_reg    <= wr_be_next;
      crc_err_reg  <= crc_err_next;
    end
  end

  assign wr_valid = wr_valid_reg;
  assign wr_data  = wr_data_reg;
  assign wr_be    = wr_be_reg;
  assign crc_err  = crc_err_reg;
endmodule // wcrc_device

// ===== wcrc_host.sv
`timescale 1ns/1ps
`include "wcrc_defines.svh"
module wcrc_host (
  // System side
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Configuration
  input  wire logic        dm_en,
  input  wire logic        dbi_en,
  // Write request
  input  wire logic        req_valid,
  input  wire logic        req_a2,
  input  wire logic [63:0] req_data,
  input  wire logic [7:0]  req_dmi,
  output logic             req_ready,
  // Link
  wcrc_link_if.host        lnk
);
  import wcrc_pkg::*;

  wcrc_state_t state_reg, state_next;
  logic        clk_reg,   clk_next;
  logic [3:0]  beat_reg,  beat_next;
  logic        rdy_reg,   rdy_next;
  logic        frame_reg, frame_next;
  logic        a2_reg,    a2_next;
  logic [15:0] dq_reg,    dq_next;
  logic [1:0]  dmi_reg,   dmi_next;
  logic [63:0] data_reg,  data_next;
  logic [7:0]  mk_reg,    mk_next;
  logic [15:0] crc_reg,   crc_next;

  // Divide-by-two link clock; pins change as it falls
  always_comb begin
    logic [31:0] lo4;
    logic [31:0] hi4;
    logic        launch;
    logic [3:0]  nb;
    lo4        = '0;
    hi4        = '0;
    launch     = clk_reg;
    nb         = beat_reg + 4'd1;
    clk_next   = !clk_reg;
    state_next = state_reg;
    beat_next  = beat_reg;
    rdy_next   = rdy_reg;
    frame_next = frame_reg;
    a2_next    = a2_reg;
    dq_next    = dq_reg;
    dmi_next   = dmi_reg;
    data_next  = data_reg;
    mk_next    = mk_reg;
    crc_next   = crc_reg;
    for (int b = 0; b < 4; b++) begin
      for (int k = 0; k < 8; k++) begin
        lo4[4*k + b] = req_data[b*16 + k];
        hi4[4*k + b] = req_data[b*16 + 8 + k];
      end
    end
    unique case (state_reg)
      WCRC_IDLE: begin
        // Only plain writes leave this end
        if (launch && req_valid && rdy_reg) begin // R12 R13
          state_next = WCRC_SEND;
          rdy_next   = 1'b0;
          beat_next  = `WCRC_FIRST_UI;
          frame_next = 1'b1;
          a2_next    = req_a2;
          data_next  = req_data;
          mk_next    = req_dmi;
          crc_next   = {wcrc_calc(wcrc_tree(hi4, req_dmi[7:4], req_a2, dm_en | dbi_en)),
                        wcrc_calc(wcrc_tree(lo4, req_dmi[3:0], req_a2, dm_en | dbi_en))}; // R4 R5 R6 R7 R8
          dq_next    = req_data[15:0]; // R1 R2
          dmi_next   = {req_dmi[4], req_dmi[0]}; // R3
        end
      end
      WCRC_SEND: begin
        if (launch) begin
          if (beat_reg == `WCRC_LAST_UI) begin // R14
            state_next = WCRC_IDLE;
            rdy_next   = 1'b1;
            frame_next = 1'b0;
            dq_next    = `WCRC_DQ_IDLE;
            dmi_next   = `WCRC_DMI_IDLE;
          end else begin
            beat_next = nb;
            dq_next   = `WCRC_DQ_IDLE;
            dmi_next  = `WCRC_DMI_IDLE;
            if (nb < `WCRC_DATA_UI) begin // R1 R2 R3
              dq_next  = data_reg[nb[1:0]*16 +: 16];
              dmi_next = {mk_reg[4 + nb[1:0]], mk_reg[nb[1:0]]};
            end else if (nb == `WCRC_CRC_UI) begin
              dq_next = crc_reg; // R1 R2
            end
          end
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= WCRC_IDLE;
      clk_reg   <= 1'b0;
      beat_reg  <= `WCRC_CNT_RST;
      rdy_reg   <= 1'b1;
      frame_reg <= 1'b0;
      a2_reg    <= 1'b0;
      dq_reg    <= `WCRC_DQ_IDLE;
      dmi_reg   <= `WCRC_DMI_IDLE;
      data_reg  <= '0;
      mk_reg    <= 8'hFF;
      crc_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      clk_reg   <= clk_next;
      beat_reg  <= beat_next;
      rdy_reg   <= rdy_next;
      frame_reg <= frame_next;
      a2_reg    <= a2_next;
      dq_reg    <= dq_next;
      dmi_reg   <= dmi_next;
      data_reg  <= data_next;
      mk_reg    <= mk_next;
      crc_reg   <= crc_next;
    end
  end

  assign req_ready    = rdy_reg;
  assign lnk.link_clk = clk_reg;
  assign lnk.frame    = frame_reg;
  assign lnk.a2       = a2_reg;
  assign lnk.dq       = dq_reg;
  assign lnk.dmi      = dmi_reg;
endmodule // wcrc_host

// ===== wcrc_ref_pkg.sv
package wcrc_ref_pkg;
  // Reference checksum pair {upper, lower}: poly 07, init 00, tree bit 71 first
  function automatic logic [15:0] wcrc_ref_crc(input logic [63:0] d, input logic [7:0] m,
                                               input logic a2, input logic en);
    logic [71:0] t;
    logic [15:0] r;
    for (int j = 0; j < 2; j++) begin
      t = '1;
      for (int b = 0; b < 4; b++) begin
        for (int k = 0; k < 8; k++)
          t[8*k + (a2 ? 4 : 0) + b] = d[16*b + 8*j + k];
        if (en)
          t[64 + (a2 ? 4 : 0) + b] = m[4*j + b];
      end
      r[8*j +: 8] = 8'h00;
      for (int i = 71; i >= 0; i--)
        r[8*j +: 8] = {r[8*j +: 7], 1'h0} ^ ((r[8*j+7] ^ t[i]) ? 8'h07 : 8'h00);
    end
    return r;
  endfunction
endpackage

// ===== wcrc_sva.sv
`timescale 1ns/1ps
module wcrc_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Configuration
  input wire logic        dm_en,
  input wire logic        dbi_en,
  // Link
  input wire logic        frame,
  input wire logic        a2,
  input wire logic [15:0] dq,
  input wire logic [1:0]  dmi
);
  import wcrc_ref_pkg::*;
  logic [4:0]  cnt_reg, cnt_next;
  logic [63:0] cap_reg, cap_next;
  logic [7:0]  capm_reg, capm_next;
  logic [3:0]  ui;
  assign ui = cnt_reg[4:1];
  // Frame length count and capture of data beats
  always_comb begin
    cnt_next  = frame ? cnt_reg + 5'h01 : 5'h00;
    cap_next  = cap_reg;
    capm_next = capm_reg;
    if (frame && ui < 4'h4) begin
      cap_next[16*ui +: 16] = dq;
      capm_next[ui]         = dmi[0];
      capm_next[ui + 4'h4]  = dmi[1];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= 5'h00;
      cap_reg  <= 64'h0;
      capm_reg <= 8'hFF;
    end else begin
      cnt_reg  <= cnt_next;
      cap_reg  <= cap_next;
      capm_reg <= capm_next;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_frame_ten_ui: assert property ($fell(frame) |-> cnt_reg == 5'h14)
    else $error("frame not ten link cycles");
  a_frame_bound: assert property (frame |-> cnt_reg < 5'h14)
    else $error("frame too long");
  a_fill_ones: assert property (frame && ui inside {[4:7]} |-> dq == 16'hFFFF && dmi == 2'h3)
    else $error("fill beats not ones");
  a_tail_ones: assert property (frame && ui == 4'h9 |-> dq == 16'hFFFF && dmi == 2'h3)
    else $error("last beat not ones");
  a_mask_no_crc: assert property (frame && ui == 4'h8 |-> dmi == 2'h3)
    else $error("mask lane carries checksum");
  a_crc_pair: assert property (frame && ui == 4'h8 |-> dq == wcrc_ref_crc(cap_reg, capm_reg, a2, dm_en | dbi_en))
    else $error("checksum beat wrong");
  a_a2_held: assert property (frame && !$rose(frame) |-> $stable(a2))
    else $error("a2 changed in frame");
  a_idle_ones: assert property (!frame |-> dq == 16'hFFFF && dmi == 2'h3)
    else $error("idle lines not ones");
endmodule // wcrc_sva

// ===== test_write_crc_bc4_check.sv
`timescale 1ns/1ps
module test_write_crc_bc4_check;
  import wcrc_ref_pkg::*;
  typedef struct packed {logic [63:0] d; logic [7:0] m; logic a2; logic dm; logic dbi;} wcrc_case_t;
  logic        clk_sys   = 1'h0;
  logic        rst_b     = 1'h0;
  logic        dm_en     = 1'h0;
  logic        dbi_en    = 1'h0;
  logic        req_valid = 1'h0;
  logic        req_a2    = 1'h0;
  logic [63:0] req_data  = 64'h0;
  logic [7:0]  req_dmi   = 8'hFF;
  logic        req_ready, wr_valid, b_valid;
  logic [63:0] wr_data, b_data;
  logic [7:0]  wr_be, b_be;
  logic [1:0]  crc_err, b_err;
  int          err_total  = 0;
  int          n_compared = 0;
  wcrc_case_t  tc [6];
  wcrc_link_if lnk ();
  wcrc_link_if lnk_bad ();
  // System clock
  always #12.5 clk_sys = ~clk_sys;
  // Both ends, a second device fed by the bench, and the wire checker
  wcrc_host i_wcrc_host (.clk_sys(clk_sys), .rst_b(rst_b), .dm_en(dm_en), .dbi_en(dbi_en),
    .req_valid(req_valid), .req_a2(req_a2), .req_data(req_data), .req_dmi(req_dmi),
    .req_ready(req_ready), .lnk(lnk));
  wcrc_device i_wcrc_device (.clk_sys(clk_sys), .rst_b(rst_b), .dm_en(dm_en), .dbi_en(dbi_en),
    .lnk(lnk), .wr_valid(wr_valid), .wr_data(wr_data), .wr_be(wr_be), .crc_err(crc_err));
  wcrc_device i_wcrc_device_bad (.clk_sys(clk_sys), .rst_b(rst_b), .dm_en(dm_en), .dbi_en(dbi_en),
    .lnk(lnk_bad), .wr_valid(b_valid), .wr_data(b_data), .wr_be(b_be), .crc_err(b_err));
  wcrc_sva i_wcrc_sva (.clk_sys(clk_sys), .rst_b(rst_b), .dm_en(dm_en), .dbi_en(dbi_en),
    .frame(lnk.frame), .a2(lnk.a2), .dq(lnk.dq), .dmi(lnk.dmi));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Bounded wait: 0 commit, 1 second device commit, 2 request taken
  task automatic wait_on(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((s == 0 ? wr_valid : s == 1 ? b_valid : !req_ready) !== 1'h1 && n < 60);
    if ((s == 0 ? wr_valid : s == 1 ? b_valid : !req_ready) !== 1'h1) begin
      err_total++;
      $display("unexpected wait %0d: expected 1 seen timeout", s);
      results();
    end
  endtask

  // One write through both ends, checked at the commit port
  task automatic xfer(input wcrc_case_t c);
    logic [63:0] xd;
    logic [7:0]  be;
    xd = c.d;
    be = 8'hFF;
    for (int b = 0; b < 4; b++)
      for (int j = 0; j < 2; j++)
        if (!c.m[4*j+b]) begin
          be[2*b+j] = be[2*b+j] & !c.dm;
          if (c.dbi)
            xd[16*b+8*j +: 8] = ~xd[16*b+8*j +: 8];
        end
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_data  <= c.d;
    req_dmi   <= c.m;
    req_a2    <= c.a2;
    wait_on(2);
    @(posedge clk_sys);
    req_valid <= 1'h0;
    wait_on(0);
    check("data", wr_data, xd);
    check("byte enables", wr_be, be);
    check("crc error", crc_err, 2'h0);
  endtask

  // Frame on the second link with checksum bits flipped on purpose
  task automatic bad_xfer(input logic [63:0] d, input logic a2, input logic [1:0] err);
    logic [15:0] crc;
    crc = wcrc_ref_crc(d, 8'hFF, a2, 1'h0) ^ {7'h00, err[1], 7'h00, err[0]};
    lnk_bad.a2 <= a2;
    for (int u = 0; u < 11; u++) begin
      lnk_bad.frame <= (u < 10);
      lnk_bad.dq    <= (u < 4) ? d[16*u +: 16] : ((u == 8) ? crc : 16'hFFFF);
      #7.5;
      lnk_bad.link_clk = 1'h1;
      #7.5;
      lnk_bad.link_clk = 1'h0;
    end
    wait_on(1);
    check("error flags", b_err, err);
    check("blocked bytes", b_be, {4{~err[1], ~err[0]}});
    check("shown data", b_data, d);
  endtask

  // Main sequence
  initial begin
    lnk_bad.link_clk = 1'h0;
    lnk_bad.frame = 1'h0;
    lnk_bad.a2 = 1'h0;
    lnk_bad.dq = 16'hFFFF;
    lnk_bad.dmi = 2'h3;
    tc[0] = '{64'h0123456789ABCDEF, 8'hFF, 1'h0, 1'h0, 1'h0};
    tc[1] = '{64'hFEDCBA9876543210, 8'hFF, 1'h1, 1'h0, 1'h0};
    tc[2] = '{64'h8000000000000001, 8'h0F, 1'h0, 1'h0, 1'h0};
    tc[3] = '{64'h0000000000000000, 8'hA5, 1'h1, 1'h1, 1'h0};
    tc[4] = '{64'hFFFFFFFFFFFFFFFF, 8'h3C, 1'h0, 1'h1, 1'h0};
    tc[5] = '{64'hDEADBEEFCAFE8001, 8'h5A, 1'h1, 1'h0, 1'h1};
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'h1;
    for (int i = 0; i < 4; i++)
      bad_xfer(64'h3C5A96F01E2D4B87 + i, i[0], i[1:0]);
    for (int i = 0; i < 6; i++) begin
      if (tc[i].dm !== dm_en || tc[i].dbi !== dbi_en) begin
        @(posedge clk_sys);
        dm_en  <= tc[i].dm;
        dbi_en <= tc[i].dbi;
        repeat (12) @(posedge clk_sys);
      end
      xfer(tc[i]);
    end
    results();
  end
endmodule // test_write_crc_bc4_check
